// *** hdl/mcd_pkg.sv ***
// Shared constants, types and byte decoding for the MAC client dataplane and reset block
package mcd_pkg;
   // Client word layout
   localparam int DATA_W = 64;
   localparam int BYTE_W = 8;
   localparam int BYTES = DATA_W / BYTE_W;
   localparam int BC_W = 3;
   localparam int PRE_W = 56;
   localparam int FCS_W = 2;
   localparam int GAP_W = 8;

   // Buffer sizing: almost full leaves room for this many further writes
   localparam int FIFO_DEPTH = 16;
   localparam int AFULL_SLACK = 4;

   // Reset stretch after the request drops, and spacing between the two releases
   localparam int RST_STRETCH = 48;
   localparam int RST_ORDER_GAP = 4;

   // Field defaults when the qualifying marker is absent
   localparam logic [BC_W-1:0] BC_ALL = 3'h0;
   localparam logic [FCS_W-1:0] FCS_NONE = 2'h0;
   localparam logic [GAP_W-1:0] GAP_NONE = 8'h00;
   localparam logic [PRE_W-1:0] PRE_NONE = 56'h00000000000000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {
      MCD_IDLE = 2'h1,
      MCD_IN_PKT = 2'h2
   } mcd_frame_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic [BC_W-1:0] bc;
      logic [PRE_W-1:0] pre;
      logic [FCS_W-1:0] fcs;
      logic [GAP_W-1:0] gap;
      logic [DATA_W-1:0] data;
   } mcd_word_t;

   localparam int WORD_W = $bits(mcd_word_t);

   // Zero the lanes above the byte count; a count of zero means all lanes
   function automatic logic [DATA_W-1:0] mcd_keep_bytes(input logic [DATA_W-1:0] d,
                                                       input logic [BC_W-1:0] bc);
      logic [DATA_W-1:0] r;
      r = d;
      for (int i = 0; i < BYTES; i++) begin
         if (bc != BC_ALL && i >= int'(bc)) begin
            r[i*BYTE_W +: BYTE_W] = BYTE_ZERO;
         end
      end
      return r;
   endfunction
endpackage

// *** hdl/mcd_fifo.sv ***
// Packet word buffer with registered read data, almost-full flag and clean drop
`timescale 1ns/100ps
module mcd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16,
   parameter int SLACK = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clear,
   // Write side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic almost_full,
   output logic drop,
   // Read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // DEPTH must be a power of two so the pointers wrap naturally
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_THRESH = (AW+1)'(DEPTH - SLACK);
   localparam logic [AW:0] CNT_ZERO = '0;
   localparam logic [AW-1:0] PTR_ONE = AW'(1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic ov;
      logic [W-1:0] od;
      logic drop;
   } mcd_fifo_st_t;

   mcd_fifo_st_t s;
   mcd_fifo_st_t n;
   logic push;
   logic pop;

   always_comb begin
      n = s;
      n.drop = 1'b0;
      // Writes while the buffer is full are refused without touching pointers
      push = in_valid && (s.count != CNT_FULL);
      pop = (s.count != CNT_ZERO) && (!s.ov || out_ready);
      if (in_valid && !push) begin
         n.drop = 1'b1;
      end
      if (push) begin
         n.mem[s.wr] = in_data;
         n.wr = s.wr + PTR_ONE;
      end
      if (pop) begin
         n.od = s.mem[s.rd];
         n.rd = s.rd + PTR_ONE;
         n.ov = 1'b1;
      end else if (out_ready) begin
         n.ov = 1'b0;
      end
      n.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
      if (clear) begin
         n = '0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Flag follows the write that reaches the threshold by one edge
   assign almost_full = (s.count >= CNT_THRESH);
   assign drop = s.drop;
   assign out_valid = s.ov;
   assign out_data = s.od;
endmodule

// *** hdl/mcd_rst.sv ***
// Reset stretcher that releases two reset outputs in a fixed order
`timescale 1ns/100ps
module mcd_rst #(
   parameter int STRETCH = 48,
   parameter int GAP = 4,
   parameter bit CORE_FIRST = 1'b1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Request and outputs
   input wire logic request,
   output logic system_side_reset,
   output logic core_side_reset
);
   localparam int CW = $clog2(STRETCH + GAP + 1);
   localparam logic [CW-1:0] CNT_FIRST = CW'(STRETCH - 1);
   localparam logic [CW-1:0] CNT_SECOND = CW'(STRETCH + GAP - 1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic hold_first;
      logic hold_second;
   } mcd_rst_st_t;

   localparam mcd_rst_st_t RST_VAL = '{cnt: '0, hold_first: 1'h1, hold_second: 1'h1};

   mcd_rst_st_t s;
   mcd_rst_st_t n;

   always_comb begin
      n = s;
      // A request of any length, even one cycle, restarts the whole stretch
      if (request) begin
         n = RST_VAL;
      end else begin
         if (s.cnt != CNT_SECOND) begin
            n.cnt = s.cnt + CNT_ONE;
         end
         if (s.cnt >= CNT_FIRST) begin
            n.hold_first = 1'b0;
         end
         if (s.cnt >= CNT_SECOND) begin
            n.hold_second = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s <= RST_VAL;
      end else begin
         s <= n;
      end
   end

   // Both outputs leave flip-flops on the one clock, so the order holds
   assign core_side_reset = CORE_FIRST ? s.hold_first : s.hold_second;
   assign system_side_reset = CORE_FIRST ? s.hold_second : s.hold_first;
endmodule

// *** hdl/mcd_top.sv ***
// MAC client dataplane: transmit and receive packet buffers with master reset control
`timescale 1ns/100ps

// Functional notes
// - Only end word partial; honour its byte count
// - Almost full, then four more writes accepted
// - Writes beyond that dropped cleanly
// - Receive start and end marked with valid
// - Receive end word carries active byte count
// - Receive valid never underruns or overflows FIFO
// - Receive signals mirror transmit signals; the receive side here has no FCS controls, gap count or ready
// - Both resets held during and after request
// - Resets stretched a fixed count after release
// - Transmit: core reset released before system
// - Receive: system reset released before core
module mcd_top #(
   parameter int DEPTH = mcd_pkg::FIFO_DEPTH,
   parameter int SLACK = mcd_pkg::AFULL_SLACK,
   parameter int STRETCH = mcd_pkg::RST_STRETCH,
   parameter int ORDER_GAP = mcd_pkg::RST_ORDER_GAP
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,

   // Reset requests and controlled resets
   input wire logic tx_reset_request_in,
   input wire logic rx_reset_request_in,
   output logic tx_system_side_reset_out,
   output logic tx_core_side_reset_out,
   output logic rx_system_side_reset_out,
   output logic rx_core_side_reset_out,

   // Transmit client write port
   input wire logic tx_client_valid,
   input wire logic tx_client_start_marker,
   input wire logic tx_client_end_marker,
   input wire logic [mcd_pkg::DATA_W-1:0] tx_client_data,
   input wire logic [mcd_pkg::PRE_W-1:0] tx_client_preamble,
   input wire logic [mcd_pkg::FCS_W-1:0] tx_client_fcs_controls,
   input wire logic [mcd_pkg::BC_W-1:0] tx_client_last_byte_count,
   input wire logic [mcd_pkg::GAP_W-1:0] tx_client_gap_count,
   output logic tx_client_almost_full,
   output logic tx_client_drop,
   output logic tx_client_frame_error,

   // Transmit core read port
   output logic tx_core_valid,
   input wire logic tx_core_ready,
   output logic tx_core_start_marker,
   output logic tx_core_end_marker,
   output logic [mcd_pkg::DATA_W-1:0] tx_core_data,
   output logic [mcd_pkg::PRE_W-1:0] tx_core_preamble,
   output logic [mcd_pkg::FCS_W-1:0] tx_core_fcs_controls,
   output logic [mcd_pkg::BC_W-1:0] tx_core_last_byte_count,
   output logic [mcd_pkg::GAP_W-1:0] tx_core_gap_count,

   // Receive core write port
   input wire logic rx_core_valid,
   input wire logic rx_core_start_marker,
   input wire logic rx_core_end_marker,
   input wire logic [mcd_pkg::DATA_W-1:0] rx_core_data,
   input wire logic [mcd_pkg::PRE_W-1:0] rx_core_preamble,
   input wire logic [mcd_pkg::BC_W-1:0] rx_core_last_byte_count,
   output logic rx_core_almost_full,
   output logic rx_core_drop,
   output logic rx_core_frame_error,

   // Receive client read port
   output logic rx_client_valid,
   output logic rx_client_start_marker,
   output logic rx_client_end_marker,
   output logic [mcd_pkg::DATA_W-1:0] rx_client_data,
   output logic [mcd_pkg::PRE_W-1:0] rx_client_preamble,
   output logic [mcd_pkg::BC_W-1:0] rx_client_last_byte_count
);

   typedef struct packed {
      mcd_pkg::mcd_frame_t tx_frame;
      mcd_pkg::mcd_frame_t rx_frame;
      logic tx_err;
      logic rx_err;
   } mcd_top_st_t;

   localparam mcd_top_st_t TOP_RST = '{
      tx_frame: mcd_pkg::MCD_IDLE,
      rx_frame: mcd_pkg::MCD_IDLE,
      tx_err: 1'h0,
      rx_err: 1'h0
   };

   mcd_top_st_t s;
   mcd_top_st_t n;

   logic [3:0] tx_step;
   logic [3:0] rx_step;
   logic tx_push;
   logic rx_push;
   mcd_pkg::mcd_word_t tx_in;
   mcd_pkg::mcd_word_t rx_in;
   mcd_pkg::mcd_word_t tx_out;
   mcd_pkg::mcd_word_t rx_out;
   logic tx_buf_valid;
   logic rx_buf_valid;

   // Framing step shared by both directions: {accept, error, next state}
   function automatic logic [3:0] frame_step(input mcd_pkg::mcd_frame_t st,
                                             input logic vld,
                                             input logic sop,
                                             input logic eop);
      mcd_pkg::mcd_frame_t nxt;
      logic acc;
      logic err;
      nxt = st;
      acc = 1'b0;
      err = 1'b0;
      if (vld) begin
         unique case (st)
            mcd_pkg::MCD_IDLE: begin
               if (sop) begin
                  acc = 1'b1;
                  nxt = eop ? mcd_pkg::MCD_IDLE : mcd_pkg::MCD_IN_PKT;
               end else begin
                  // A word with no packet open has nowhere to go
                  err = 1'b1;
               end
            end
            mcd_pkg::MCD_IN_PKT: begin
               // A fresh start inside a packet is kept but reported
               acc = 1'b1;
               err = sop;
               nxt = eop ? mcd_pkg::MCD_IDLE : mcd_pkg::MCD_IN_PKT;
            end
            default: begin
               nxt = mcd_pkg::MCD_IDLE;
               err = 1'b1;
            end
         endcase
      end
      return {acc, err, nxt};
   endfunction

   always_comb begin
      n = s;

      // Transmit framing on qualified writes only
      tx_step = frame_step(s.tx_frame, tx_client_valid && !tx_system_side_reset_out,
                           tx_client_start_marker, tx_client_end_marker);
      tx_push = tx_step[3];
      n.tx_err = tx_step[2];
      n.tx_frame = mcd_pkg::mcd_frame_t'(tx_step[1:0]);

      // Preamble kept only on the start word, tail fields only on the end word
      tx_in.start = tx_client_start_marker;
      tx_in.stop = tx_client_end_marker;
      tx_in.pre = tx_client_start_marker ? tx_client_preamble : mcd_pkg::PRE_NONE;
      tx_in.bc = tx_client_end_marker ? tx_client_last_byte_count : mcd_pkg::BC_ALL;
      tx_in.fcs = tx_client_end_marker ? tx_client_fcs_controls : mcd_pkg::FCS_NONE;
      tx_in.gap = tx_client_end_marker ? tx_client_gap_count : mcd_pkg::GAP_NONE;
      // Inactive lanes of the end word are zeroed before buffering
      tx_in.data = mcd_pkg::mcd_keep_bytes(tx_client_data, tx_in.bc);

      // Receive framing mirrors transmit
      rx_step = frame_step(s.rx_frame, rx_core_valid && !rx_core_side_reset_out,
                           rx_core_start_marker, rx_core_end_marker);
      rx_push = rx_step[3];
      n.rx_err = rx_step[2];
      n.rx_frame = mcd_pkg::mcd_frame_t'(rx_step[1:0]);

      rx_in.start = rx_core_start_marker;
      rx_in.stop = rx_core_end_marker;
      rx_in.pre = rx_core_start_marker ? rx_core_preamble : mcd_pkg::PRE_NONE;
      rx_in.bc = rx_core_end_marker ? rx_core_last_byte_count : mcd_pkg::BC_ALL;
      rx_in.fcs = mcd_pkg::FCS_NONE;
      rx_in.gap = mcd_pkg::GAP_NONE;
      rx_in.data = mcd_pkg::mcd_keep_bytes(rx_core_data, rx_in.bc);

      // A side held in reset forgets any open packet
      if (tx_system_side_reset_out) begin
         n.tx_frame = mcd_pkg::MCD_IDLE;
      end
      if (rx_core_side_reset_out) begin
         n.rx_frame = mcd_pkg::MCD_IDLE;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s <= TOP_RST;
      end else begin
         s <= n;
      end
   end

   // Transmit: core side leaves reset first so it is ready to drain
   mcd_rst #(
      .STRETCH(STRETCH),
      .GAP(ORDER_GAP),
      .CORE_FIRST(1'b1)
   ) u_tx_rst (
      .clock(clock),
      .sys_rst(sys_rst),
      .request(tx_reset_request_in),
      .system_side_reset(tx_system_side_reset_out),
      .core_side_reset(tx_core_side_reset_out)
   );

   // Receive: system side leaves reset first so it is ready to accept
   mcd_rst #(
      .STRETCH(STRETCH),
      .GAP(ORDER_GAP),
      .CORE_FIRST(1'b0)
   ) u_rx_rst (
      .clock(clock),
      .sys_rst(sys_rst),
      .request(rx_reset_request_in),
      .system_side_reset(rx_system_side_reset_out),
      .core_side_reset(rx_core_side_reset_out)
   );

   // Transmit buffer: user writes, core drains
   mcd_fifo #(
      .W(mcd_pkg::WORD_W),
      .DEPTH(DEPTH),
      .SLACK(SLACK)
   ) u_tx_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .clear(tx_system_side_reset_out),
      .in_valid(tx_push),
      .in_data(tx_in),
      .almost_full(tx_client_almost_full),
      .drop(tx_client_drop),
      .out_valid(tx_buf_valid),
      .out_ready(tx_core_ready && !tx_core_side_reset_out),
      .out_data(tx_out)
   );

   // Receive buffer: core writes, user sink takes every presented word
   mcd_fifo #(
      .W(mcd_pkg::WORD_W),
      .DEPTH(DEPTH),
      .SLACK(SLACK)
   ) u_rx_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .clear(rx_system_side_reset_out),
      .in_valid(rx_push),
      .in_data(rx_in),
      .almost_full(rx_core_almost_full),
      .drop(rx_core_drop),
      .out_valid(rx_buf_valid),
      .out_ready(1'b1),
      .out_data(rx_out)
   );

   assign tx_client_frame_error = s.tx_err;
   assign rx_core_frame_error = s.rx_err;

   // Transmit core outputs
   assign tx_core_valid = tx_buf_valid && !tx_core_side_reset_out;
   assign tx_core_start_marker = tx_out.start;
   assign tx_core_end_marker = tx_out.stop;
   assign tx_core_data = tx_out.data;
   assign tx_core_preamble = tx_out.pre;
   assign tx_core_fcs_controls = tx_out.fcs;
   assign tx_core_last_byte_count = tx_out.bc;
   assign tx_core_gap_count = tx_out.gap;

   // Receive client outputs; valid only when a buffered word exists, so no underrun
   assign rx_client_valid = rx_buf_valid && !rx_system_side_reset_out;
   assign rx_client_start_marker = rx_out.start;
   assign rx_client_end_marker = rx_out.stop;
   assign rx_client_data = rx_out.data;
   assign rx_client_preamble = rx_out.pre;
   assign rx_client_last_byte_count = rx_out.bc;
endmodule

// *** sim/mcd_sva.sv ***
// Port checks for the client dataplane and reset controller
`timescale 1ns/100ps
module mcd_sva #(
   parameter int ORDER_GAP = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Reset control
   input wire logic tx_reset_request_in,
   input wire logic rx_reset_request_in,
   input wire logic tx_system_side_reset_out,
   input wire logic tx_core_side_reset_out,
   input wire logic rx_system_side_reset_out,
   input wire logic rx_core_side_reset_out,
   // Dataplane
   input wire logic tx_client_almost_full,
   input wire logic tx_client_drop,
   input wire logic rx_core_valid,
   input wire logic rx_core_start_marker,
   input wire logic rx_core_almost_full,
   input wire logic rx_client_valid,
   input wire logic rx_client_start_marker
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_tx_both;
      tx_system_side_reset_out && tx_core_side_reset_out;
   endsequence
   sequence s_rx_both;
      rx_system_side_reset_out && rx_core_side_reset_out;
   endsequence
   sequence s_rx_start_in;
      rx_core_valid && rx_core_start_marker && !rx_core_side_reset_out
         && !rx_core_almost_full && !rx_reset_request_in;
   endsequence
   property p_tx_req_hold;
      tx_reset_request_in |=> s_tx_both;
   endproperty
   a_tx_req_hold: assert property (p_tx_req_hold) else $error("tx resets low");
   property p_rx_req_hold;
      rx_reset_request_in |=> s_rx_both;
   endproperty
   a_rx_req_hold: assert property (p_rx_req_hold) else $error("rx resets low");
   // Short stretch floor so a tiny test stretch still fits
   property p_tx_stretch;
      $fell(tx_reset_request_in) |-> s_tx_both [*3];
   endproperty
   a_tx_stretch: assert property (p_tx_stretch) else $error("tx stretch short");
   property p_rx_stretch;
      $fell(rx_reset_request_in) |-> s_rx_both [*3];
   endproperty
   a_rx_stretch: assert property (p_rx_stretch) else $error("rx stretch short");
   property p_tx_order;
      $fell(tx_core_side_reset_out) && !tx_reset_request_in
         |-> tx_system_side_reset_out ##ORDER_GAP !tx_system_side_reset_out;
   endproperty
   a_tx_order: assert property (p_tx_order) else $error("tx release order");
   property p_rx_order;
      $fell(rx_system_side_reset_out) && !rx_reset_request_in
         |-> rx_core_side_reset_out ##ORDER_GAP !rx_core_side_reset_out;
   endproperty
   a_rx_order: assert property (p_rx_order) else $error("rx release order");
   property p_af_slack;
      $rose(tx_client_almost_full) |-> !tx_client_drop [*5];
   endproperty
   a_af_slack: assert property (p_af_slack) else $error("early drop");
   property p_drop_full;
      tx_client_drop |-> tx_client_almost_full;
   endproperty
   a_drop_full: assert property (p_drop_full) else $error("drop below threshold");
   property p_rx_gate;
      rx_system_side_reset_out |-> !rx_client_valid;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("rx valid in reset");
   property p_rx_lat;
      s_rx_start_in |-> ##2 rx_client_valid && rx_client_start_marker;
   endproperty
   a_rx_lat: assert property (p_rx_lat) else $error("rx start lost");
endmodule
bind mcd_top mcd_sva #(.ORDER_GAP(ORDER_GAP)) sva_u (.*);

// *** sim/mcd_partner.sv ***
// User packet source model for one client write port
`timescale 1ns/100ps
module mcd_partner (
   // Clock
   input wire logic clock,
   // Client write port
   output logic valid,
   output logic start_m,
   output logic end_m,
   output logic [mcd_pkg::DATA_W-1:0] data,
   output logic [mcd_pkg::PRE_W-1:0] pre,
   output logic [mcd_pkg::FCS_W-1:0] fcs,
   output logic [mcd_pkg::BC_W-1:0] bc,
   output logic [mcd_pkg::GAP_W-1:0] gap
);
   initial begin
      valid = 1'b0;
      {start_m, end_m, data, pre, fcs, bc, gap} = '0;
   end
   // Unqualified lines carry junk so stale values cannot pass for good ones
   task automatic scramble();
      data = ~data;
      pre = ~pre;
      fcs = ~fcs;
      gap = gap + 8'h5B;
   endtask
   // Word stays driven until the next call, so back-to-back writes hold across the edge
   task automatic put(input logic s, input logic e, input logic [2:0] b, input logic [63:0] d);
      @(posedge clock);
      #1;
      scramble();
      valid = 1'b1;
      start_m = s;
      end_m = e;
      bc = e ? b : ~b;
      data = d;
   endtask
   task automatic idle();
      @(posedge clock);
      #1;
      scramble();
      valid = 1'b0;
      start_m = ~start_m;
      end_m = ~end_m;
   endtask
endmodule

// *** sim/mcd_top_tb_top.sv ***
// Self-checking bench for the client dataplane and reset block
`timescale 1ns/100ps
module mcd_top_tb_top;
   localparam int STR = 4;
   localparam int GAP = 1;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic tx_req = 1'b0;
   logic rx_req = 1'b0;
   logic rdy = 1'b0;
   logic [1:0] rmode = 2'h0;
   bit gaps = 1'b1;
   int err_count = 0;
   int checked = 0;
   logic [134:0] tx_q[$];
   logic [134:0] rx_q[$];
   logic tx_sr, tx_cr, rx_sr, rx_cr, tx_af, tx_drop, tcv, tcs, tce, rcv, rcs, rce;
   logic tv, ts, te, rv, rs, re;
   logic [2:0] tcb, rcb, tb, rb;
   logic [63:0] tcd, rcd, td, rd;
   logic [55:0] tcp, rcp, tp, rp;
   logic [1:0] tf;
   logic [7:0] tg;
   logic [1:0] tcf;
   logic [7:0] tcg;
   logic terr;
   always #25 clock = ~clock;
   mcd_partner tx_src (.clock(clock), .valid(tv), .start_m(ts), .end_m(te), .data(td), .pre(tp),
      .fcs(tf), .bc(tb), .gap(tg));
   mcd_partner rx_src (.clock(clock), .valid(rv), .start_m(rs), .end_m(re), .data(rd), .pre(rp),
      .fcs(), .bc(rb), .gap());
   mcd_top #(.STRETCH(STR), .ORDER_GAP(GAP)) dut_u (.clock(clock), .sys_rst(sys_rst),
      .tx_reset_request_in(tx_req), .rx_reset_request_in(rx_req),
      .tx_system_side_reset_out(tx_sr), .tx_core_side_reset_out(tx_cr),
      .rx_system_side_reset_out(rx_sr), .rx_core_side_reset_out(rx_cr),
      .tx_client_valid(tv), .tx_client_start_marker(ts), .tx_client_end_marker(te),
      .tx_client_data(td), .tx_client_preamble(tp), .tx_client_fcs_controls(tf),
      .tx_client_last_byte_count(tb), .tx_client_gap_count(tg), .tx_client_almost_full(tx_af),
      .tx_client_drop(tx_drop), .tx_client_frame_error(terr), .tx_core_valid(tcv),
      .tx_core_ready(rdy), .tx_core_start_marker(tcs), .tx_core_end_marker(tce),
      .tx_core_data(tcd), .tx_core_preamble(tcp), .tx_core_fcs_controls(tcf),
      .tx_core_last_byte_count(tcb), .tx_core_gap_count(tcg), .rx_core_valid(rv),
      .rx_core_start_marker(rs), .rx_core_end_marker(re), .rx_core_data(rd),
      .rx_core_preamble(rp), .rx_core_last_byte_count(rb), .rx_core_almost_full(),
      .rx_core_drop(), .rx_core_frame_error(), .rx_client_valid(rcv),
      .rx_client_start_marker(rcs), .rx_client_end_marker(rce), .rx_client_data(rcd),
      .rx_client_preamble(rcp), .rx_client_last_byte_count(rcb));
   task automatic check(input logic [134:0] seen, input logic [134:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Expected word: tail fields and count on end, preamble on start, dead lanes cleared
   function automatic logic [134:0] pack(logic s, logic e, logic [2:0] b, logic [55:0] p,
                                         logic [63:0] d, logic [1:0] f, logic [7:0] g);
      for (int i = 0; i < 8; i++) begin
         if (e && b != 3'h0 && i >= int'(b)) d[i*8 +: 8] = 8'h00;
      end
      return {(e ? f : 2'h0), (e ? g : 8'h00), s, e, (e ? b : 3'h0), (s ? p : 56'h0), d};
   endfunction
   task automatic wr(input bit rx, input bit s, input bit e, input logic [2:0] b, input bit note);
      logic [63:0] d;
      d = {$urandom, $urandom};
      if (rx) begin
         rx_src.put(s, e, b, d);
         if (note) rx_q.push_back(pack(s, e, b, rx_src.pre, d, 2'h0, 8'h00));
         if (gaps && $urandom % 3 == 0) rx_src.idle();
      end else begin
         tx_src.put(s, e, b, d);
         if (note) tx_q.push_back(pack(s, e, b, tx_src.pre, d, tx_src.fcs, tx_src.gap));
         if (gaps && $urandom % 3 == 0) tx_src.idle();
      end
   endtask
   task automatic rst_seq(input bit rx);
      int tc;
      int tsy;
      tc = 0;
      tsy = 0;
      tx_req = !rx;
      rx_req = rx;
      @(posedge clock);
      #1;
      tx_req = 1'b0;
      rx_req = 1'b0;
      check(rx ? {rx_sr, rx_cr} : {tx_sr, tx_cr}, 2'h3);
      for (int n = 1; n < 200 && (tc == 0 || tsy == 0); n++) begin
         @(posedge clock);
         #1;
         if (tc == 0 && (rx ? rx_cr : tx_cr) === 1'b0) tc = n;
         if (tsy == 0 && (rx ? rx_sr : tx_sr) === 1'b0) tsy = n;
      end
      check(rx ? tsy + GAP : tc + GAP, rx ? tc : tsy);
      check(rx ? tsy : tc, STR);
      $display("test reset %0d done", rx);
   endtask
   task automatic drain(input string nm);
      for (int n = 0; n < 500 && tx_q.size() + rx_q.size() != 0; n++) @(posedge clock);
      check(tx_q.size() + rx_q.size(), 0);
      $display("test %s done", nm);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Core side takes words promptly, slowly or not at all
   always @(posedge clock) begin
      #1;
      rdy = (rmode == 2'h2) ? 1'($urandom) : rmode[0];
   end
   // Sampled mid-cycle, where the word and the core ready both stand settled
   always @(negedge clock) begin
      if (tcv === 1'b1 && rdy === 1'b1) begin
         check({tcf, tcg, tcs, tce, tcb, tcp, tcd}, tx_q.pop_front());
      end
      if (rcv === 1'b1) check({10'h000, rcs, rce, rcb, rcp, rcd}, rx_q.pop_front());
   end
   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end
   initial begin
      logic [134:0] ex;
      logic dr;
      void'($urandom(44));
      repeat (4) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      rst_seq(1'b0);
      rst_seq(1'b1);
      rmode = 2'h2;
      for (int b = 0; b < 8; b++) begin
         for (int rx = 0; rx < 2; rx++) begin
            wr(rx[0], 1'b1, 1'b0, 3'h0, 1'b1);
            wr(rx[0], 1'b0, 1'b0, 3'(b), 1'b1);
            wr(rx[0], 1'b0, 1'b1, 3'(b), 1'b1);
            if (rx == 0) tx_src.idle();
            else rx_src.idle();
         end
      end
      drain("packets");
      rmode = 2'h0;
      gaps = 1'b0;
      wr(1'b0, 1'b1, 1'b0, 3'h0, 1'b1);
      for (int n = 0; n < 40 && tx_af !== 1'b1; n++) wr(1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
      repeat (3) wr(1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
      dr = 1'b0;
      for (int k = 0; k < 4 && dr !== 1'b1; k++) begin
         wr(1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
         ex = pack(1'b0, 1'b0, 3'h0, tx_src.pre, tx_src.data, tx_src.fcs, tx_src.gap);
         tx_src.idle();
         dr = tx_drop;
         @(posedge clock);
         #1;
         dr = dr | tx_drop;
         if (dr !== 1'b1) tx_q.push_back(ex);
      end
      check(dr, 1'b1);
      // A full buffer would refuse the end word too, so let the core drain first
      rmode = 2'h2;
      for (int n = 0; n < 100 && tx_af !== 1'b0; n++) tx_src.idle();
      wr(1'b0, 1'b0, 1'b1, 3'h5, 1'b1);
      tx_src.idle();
      drain("backpressure");
      wr(1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
      tx_src.idle();
      check(terr, 1'b1);
      tx_src.idle();
      check(terr, 1'b0);
      $display("test stray done");
      give_verdict();
   end
endmodule
